// [design/badc_pkg.sv]
// constants and types of the bus area decoder and control block
package badc_pkg;
  localparam int EFF_W = 28;
  localparam int AREA_MSB = 26;
  localparam int AREA_LSB = 24;
  localparam int WSEL_BIT = 27;
  localparam int PERI_BIT = 8;
  localparam int MUXW_BIT = 14;
  // on-chip space of areas 5 and 7 is picked by this bit, our own choice
  localparam int ONCHIP_BIT = 23;
  localparam logic [7:0] CS_ONE = 8'h01;
  localparam logic [2:0] AREA_0 = 3'h0;
  localparam logic [2:0] AREA_1 = 3'h1;
  localparam logic [2:0] AREA_2 = 3'h2;
  localparam logic [2:0] AREA_3 = 3'h3;
  localparam logic [2:0] AREA_4 = 3'h4;
  localparam logic [2:0] AREA_5 = 3'h5;
  localparam logic [2:0] AREA_6 = 3'h6;
  localparam logic [2:0] AREA_7 = 3'h7;
  localparam int REG_N = 10;
  localparam int IDX_W = 28;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 29;
  localparam int BUS_CTRL = 0;
  localparam int DRAM_CTRL = 4;
  localparam logic [IDX_W-1:0] DEC_MASK = 28'hF0001FF;
  localparam logic [IDX_W-1:0] REG_IDX [REG_N] = '{
    28'h5FFFFA0, 28'h5FFFFA2, 28'h5FFFFA4, 28'h5FFFFA6,
    28'h5FFFFA8, 28'h5FFFFAA, 28'h5FFFFAC, 28'h5FFFFAE,
    28'h5FFFFB0, 28'h5FFFFB2};
  localparam logic [15:0] REG_RST [REG_N] = '{
    16'h0000, 16'hFFFF, 16'hFFFF, 16'hF800, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF};
  localparam logic [15:0] REG_WMASK [REG_N] = '{
    16'hF800, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam int BC_DRAM = 15;
  localparam int BC_MUXIO = 14;
  localparam int BC_WARP = 13;
  localparam int BC_DUTY = 12;
  localparam int BC_BAS = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [15:0] ZERO16 = 16'h0000;
  typedef enum logic [2:0] {
    SP_EXT = 3'b000, SP_ROM = 3'b001, SP_DRAM = 3'b010,
    SP_PERI = 3'b011, SP_MUXIO = 3'b100, SP_RAM = 3'b101
  } badc_space_t;
  typedef enum logic [1:0] {
    W8 = 2'b00, W16 = 2'b01, W32 = 2'b10
  } badc_width_t;
  typedef struct packed {
    logic dram_enable;
    logic muxed_io_enable;
    logic warp_mode;
    logic read_duty_35;
    logic byte_access_select;
  } badc_cfg_t;
  typedef struct packed {
    logic [2:0]  area;
    badc_space_t space;
    badc_width_t width;
    logic [7:0]  chip_select;
    logic        read_strobe;
    logic        pin_wrl;
    logic        pin_wrh;
    logic        pin_a0;
  } badc_dec_t;
endpackage

// [design/badc_top.sv]
// bus area decoder with control register bank on axi4-lite
// Summary of operation
// - only the low 28 address bits take part in decoding
// - top bits pick one of eight areas; strobes do not depend on space type
// - per-area choice of on-chip, dram, muxed i/o or external space
// - default width is 8 or 16 bits by address bit 27
// - on-chip rom and ram always 32 bits wide
// - external area 0 width follows the boot width mode pin
// - on-chip peripheral width is 8 or 16 bits by address bit 8
// - area 6 with bit 27 low: width by address bit 14
// - register decode uses bits 27-24 and 8-0 only; images repeat
// - bus control clears on power-on reset, kept otherwise
// - bit 15 makes area 1 dram; dram control only then valid
// - bit 14 makes area 6 multiplexed address/data i/o
// - bit 13 selects normal or warp mode
// - bit 12 selects 50 or 35 percent read strobe high time
// - bit 11 selects write strobe pair or byte strobe signalling
// - byte strobes share pins with write strobes and address bit 0
// - bus control bits 10-0 read zero; software writes zero
// - high byte strobe marks upper byte, low marks lower byte
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module badc_top #(
  parameter int ADDR_W = 32 // axi address width
) (
  input  wire logic               clock,      // 40 MHz system clock
  input  wire logic               rst_n,      // power-on reset, low
  input  wire logic               ce,         // clock enable
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,  // write address
  input  wire logic               s_axi_awvalid, // write addr valid
  output logic                    s_axi_awready, // write addr ready
  input  wire logic [31:0]        s_axi_wdata,   // write data
  input  wire logic [3:0]         s_axi_wstrb,   // byte enables
  input  wire logic               s_axi_wvalid,  // write data valid
  output logic                    s_axi_wready,  // write data ready
  output logic [1:0]              s_axi_bresp,   // write response
  output logic                    s_axi_bvalid,  // response valid
  input  wire logic               s_axi_bready,  // response ready
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,  // read address
  input  wire logic               s_axi_arvalid, // read addr valid
  output logic                    s_axi_arready, // read addr ready
  output logic [31:0]             s_axi_rdata,   // read data
  output logic [1:0]              s_axi_rresp,   // read response
  output logic                    s_axi_rvalid,  // read data valid
  input  wire logic               s_axi_rready,  // read data ready
  input  wire logic               acc_valid,  // cpu access request
  input  wire logic [31:0]        acc_addr,   // access address
  input  wire logic               acc_write,  // 1 write, 0 read
  input  wire logic [1:0]         acc_lanes,  // {upper, lower} byte
  input  wire logic               boot_width_mode_pin, // area 0 width
  input  wire logic               rom_onchip_enable, // on-chip rom mode
  output logic                    dec_valid,  // decode result valid
  output badc_pkg::badc_dec_t     dec,        // decode result
  output badc_pkg::badc_cfg_t     cfg,        // bus control fields
  output logic [15:0]             dram_ctrl_eff // gated dram control
);

  // reset release through two flops
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  logic [15:0] regs [badc_pkg::REG_N];
  logic        aw_full;
  logic        w_full;
  logic [badc_pkg::IDX_W-1:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        ar_take;
  logic [badc_pkg::IDX_W-1:0] ar_idx;
  logic [badc_pkg::REG_N-1:0] wr_hit;
  logic [badc_pkg::REG_N-1:0] rd_hit;
  logic [15:0] rd_part [badc_pkg::REG_N];
  logic [15:0] rd_value;

  // readies gated by ce so a frozen block takes nothing
  assign s_axi_awready = ce & ~aw_full;
  assign s_axi_wready  = ce & ~w_full;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign s_axi_bresp   = badc_pkg::RESP_OKAY;
  assign s_axi_rresp   = badc_pkg::RESP_OKAY;
  assign do_write = ce & aw_full & w_full & ~s_axi_bvalid;
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  // top address bits above the index are dropped
  assign ar_idx = s_axi_araddr[badc_pkg::IDX_MSB:badc_pkg::IDX_LSB];

  // write address holding, independent of write data
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      aw_full <= 1'b0;
      aw_idx  <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_idx  <= s_axi_awaddr[badc_pkg::IDX_MSB:badc_pkg::IDX_LSB];
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
    end
  end

  // write data holding
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response, one per completed write
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // one register per entry; ignored index bits make images repeat
  for (genvar i = 0; i < badc_pkg::REG_N; i++) begin : g_reg
    localparam logic [15:0] WM = badc_pkg::REG_WMASK[i];
    assign wr_hit[i] = ((aw_idx ^ badc_pkg::REG_IDX[i])
                        & badc_pkg::DEC_MASK) == '0;
    assign rd_hit[i] = ((ar_idx ^ badc_pkg::REG_IDX[i])
                        & badc_pkg::DEC_MASK) == '0;
    assign rd_part[i] = rd_hit[i] ? regs[i] : badc_pkg::ZERO16;
    // power-on reset only; no other event clears them
    always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
        regs[i] <= badc_pkg::REG_RST[i];
      end else if (ce && do_write && wr_hit[i]) begin
        if (w_strb[0]) begin
          regs[i][7:0] <= w_data[7:0] & WM[7:0];
        end
        if (w_strb[1]) begin
          regs[i][15:8] <= w_data[15:8] & WM[15:8];
        end
      end
    end
  end

  // or of hit-selected entries; no hit gives zero
  always_comb begin
    rd_value = badc_pkg::ZERO16;
    for (int k = 0; k < badc_pkg::REG_N; k++) begin
      rd_value = rd_value | rd_part[k];
    end
  end

  // read data channel, upper half of the word reads zero
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {badc_pkg::ZERO16, rd_value};
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // dram, muxed i/o and byte access select fields steer decode and strobe logic
  assign cfg.dram_enable = regs[badc_pkg::BUS_CTRL][badc_pkg::BC_DRAM];
  assign cfg.muxed_io_enable =
    regs[badc_pkg::BUS_CTRL][badc_pkg::BC_MUXIO];
  assign cfg.warp_mode =
    regs[badc_pkg::BUS_CTRL][badc_pkg::BC_WARP];
  assign cfg.read_duty_35 =
    regs[badc_pkg::BUS_CTRL][badc_pkg::BC_DUTY];
  assign cfg.byte_access_select =
    regs[badc_pkg::BUS_CTRL][badc_pkg::BC_BAS];
  // dram settings are held back while area 1 is plain memory
  assign dram_ctrl_eff = cfg.dram_enable ?
    regs[badc_pkg::DRAM_CTRL] : badc_pkg::ZERO16;

  // access decode; the four top architectural bits never reach it,
  // so every area image repeats across them
  logic [badc_pkg::EFF_W-1:0] ea;
  logic [2:0]                 area;
  logic                       on_chip_sel;
  badc_pkg::badc_width_t      ext_width;
  badc_pkg::badc_width_t      a6_width;
  badc_pkg::badc_width_t      peri_width;
  badc_pkg::badc_space_t      next_space;
  badc_pkg::badc_width_t      next_width;
  badc_pkg::badc_dec_t        next_dec;

  // effective address and area number
  assign ea   = acc_addr[badc_pkg::EFF_W-1:0];
  assign area = ea[badc_pkg::AREA_MSB:badc_pkg::AREA_LSB];
  // on-chip or external choice inside areas 5 and 7
  assign on_chip_sel = ea[badc_pkg::ONCHIP_BIT];

  // width candidates, each picked by one address bit
  assign ext_width = ea[badc_pkg::WSEL_BIT] ?
    badc_pkg::W16 : badc_pkg::W8;
  assign peri_width = ea[badc_pkg::PERI_BIT] ?
    badc_pkg::W16 : badc_pkg::W8;
  assign a6_width = ea[badc_pkg::MUXW_BIT] ?
    badc_pkg::W16 : badc_pkg::W8;

  // space type and width per area
  always_comb begin
    next_space = badc_pkg::SP_EXT;
    next_width = ext_width;
    unique case (area)
      badc_pkg::AREA_0: begin
        // on-chip rom is one 32-bit cycle; external width is strapped
        if (rom_onchip_enable) begin
          next_space = badc_pkg::SP_ROM;
          next_width = badc_pkg::W32;
        end else if (boot_width_mode_pin) begin
          next_width = badc_pkg::W16;
        end else begin
          next_width = badc_pkg::W8;
        end
      end
      badc_pkg::AREA_1: begin
        if (cfg.dram_enable) begin
          next_space = badc_pkg::SP_DRAM;
        end
      end
      badc_pkg::AREA_2, badc_pkg::AREA_3, badc_pkg::AREA_4: begin
        next_space = badc_pkg::SP_EXT;
      end
      badc_pkg::AREA_5: begin
        if (on_chip_sel) begin
          next_space = badc_pkg::SP_PERI;
          next_width = peri_width;
        end
      end
      badc_pkg::AREA_6: begin
        if (cfg.muxed_io_enable) begin
          next_space = badc_pkg::SP_MUXIO;
        end
        // bit 27 high keeps the default width
        if (!ea[badc_pkg::WSEL_BIT]) begin
          next_width = a6_width;
        end
      end
      badc_pkg::AREA_7: begin
        if (on_chip_sel) begin
          next_space = badc_pkg::SP_RAM;
          next_width = badc_pkg::W32;
        end
      end
    endcase
  end

  // strobe pins; the byte access select bit re-purposes three pins
  always_comb begin
    next_dec             = '0;
    next_dec.area        = area;
    next_dec.space       = next_space;
    next_dec.width       = next_width;
    next_dec.chip_select = badc_pkg::CS_ONE << area;
    next_dec.read_strobe = ~acc_write;
    if (cfg.byte_access_select) begin
      // single write, low byte and high byte strobes
      next_dec.pin_wrl = acc_write;
      next_dec.pin_wrh = acc_lanes[0];
      next_dec.pin_a0  = acc_lanes[1];
    end else begin
      // a write strobe per byte lane plus address bit 0
      next_dec.pin_wrl = acc_write & acc_lanes[0];
      next_dec.pin_wrh = acc_write & acc_lanes[1];
      next_dec.pin_a0  = ea[0];
    end
  end

  // decode result registered; held between accesses
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      dec_valid <= 1'b0;
      dec       <= '0;
    end else if (ce) begin
      dec_valid <= acc_valid;
      if (acc_valid) begin
        dec <= next_dec;
      end
    end
  end

  // checks on decode results and the register bank
  rom_width_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    dec_valid && dec.space == badc_pkg::SP_ROM
    |-> dec.width == badc_pkg::W32)
    else $error("on-chip rom access is not 32 bits wide");

  ram_width_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    dec_valid && dec.space == badc_pkg::SP_RAM
    |-> dec.width == badc_pkg::W32)
    else $error("on-chip ram access is not 32 bits wide");

  area_pick_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    acc_valid && ce
    |=> dec_valid && dec.area == $past(area))
    else $error("decoded area differs from the address");

  chip_select_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    dec_valid
    |-> $onehot(dec.chip_select) && dec.chip_select[dec.area])
    else $error("chip select does not match the area");

  area1_space_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    dec_valid && dec.area == badc_pkg::AREA_1
    |-> dec.space inside {badc_pkg::SP_EXT, badc_pkg::SP_DRAM})
    else $error("area 1 decoded as a foreign space type");

  muxio_space_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    acc_valid && ce && area == badc_pkg::AREA_6 && cfg.muxed_io_enable
    |=> dec.space == badc_pkg::SP_MUXIO)
    else $error("area 6 not multiplexed while enabled");

  single_write_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    acc_valid && ce && cfg.byte_access_select
    |=> dec.pin_wrl == $past(acc_write))
    else $error("shared write pin lost the single write strobe");

  reserved_zero_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    regs[badc_pkg::BUS_CTRL][badc_pkg::BC_BAS-1:0] == '0)
    else $error("reserved bus control bits are not zero");

  dram_gate_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    !cfg.dram_enable |-> dram_ctrl_eff == badc_pkg::ZERO16)
    else $error("dram control passed while area 1 is memory");

  unused_read_a: assert property (
    @(posedge clock) disable iff (!rst_sync)
    ar_take && rd_hit == '0 |=> s_axi_rdata == '0)
    else $error("unused register offset read not zero");

  // main scenarios reached
  rom_access_c: cover property (@(posedge clock) disable iff (!rst_sync)
    dec_valid && dec.space == badc_pkg::SP_ROM);
  dram_access_c: cover property (@(posedge clock) disable iff (!rst_sync)
    dec_valid && dec.space == badc_pkg::SP_DRAM);
  muxio_access_c: cover property (@(posedge clock) disable iff (!rst_sync)
    dec_valid && dec.space == badc_pkg::SP_MUXIO);
  byte_strobe_c: cover property (@(posedge clock) disable iff (!rst_sync)
    dec_valid && cfg.byte_access_select);
endmodule // badc_top

// [sim/badc_ext_model.sv]
// passive model of the memories and chips on the external area bus
`timescale 1ns/1ps
module badc_ext_model (
  input  wire logic                clock,     // system clock
  input  wire logic                dec_valid, // decode result valid
  input  wire badc_pkg::badc_dec_t dec,       // decode result
  output int                       n_acc      // accesses seen
);
  initial n_acc = 0;
  // a device counts every decoded access, whatever its area
  always @(posedge clock) begin
    if (dec_valid === 1'h1) n_acc <= n_acc + 1;
  end
endmodule // badc_ext_model

// [sim/badc_top_tb.sv]
// self-checking bench of the bus area decoder and control block
`timescale 1ns/1ps
module badc_top_tb;
  logic        clock = 1'h0, rst_n = 1'h0, mode_pin = 1'h0, rom_en = 1'h0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, acc_addr = '0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, acc_valid = 1'h0;
  logic        acc_write = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic        dec_valid;
  logic [1:0]  acc_lanes = '0, bresp, rresp;
  logic [15:0] dram_eff, d, mdl [10];
  logic [15:0] rst_tbl [10] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'hF800,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF};
  logic [31:0] a;
  badc_pkg::badc_dec_t dec;
  badc_pkg::badc_cfg_t cfg;
  int          err_count = 0, n_tests = 0, cyc = 0, n_acc, i, k;

  // 40 MHz, so the 35 percent read duty may be set
  initial forever #12.5 clock = ~clock;

  badc_top u_badc_top (.clock(clock), .rst_n(rst_n), .ce(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_write(acc_write), .acc_lanes(acc_lanes),
    .boot_width_mode_pin(mode_pin), .rom_onchip_enable(rom_en),
    .dec_valid(dec_valid), .dec(dec), .cfg(cfg), .dram_ctrl_eff(dram_eff));

  badc_ext_model u_badc_ext_model (.clock(clock), .dec_valid(dec_valid),
    .dec(dec), .n_acc(n_acc));

  task automatic end_sim;
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: reg %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_dec(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: decode %h exp %h", $time, g, e);
    end
  endtask

  // ignored index bits and the top address bits get random junk
  function automatic logic [31:0] img(input int r);
    logic [27:0] x;
    x = (badc_pkg::REG_IDX[r] & 28'hF0001FF) | (28'($urandom) & 28'h0FFFE00);
    return {2'($urandom), x, 2'h0};
  endfunction

  task automatic axw(input logic [31:0] ad, input logic [15:0] v);
    @(posedge clock);
    awaddr <= ad;
    wdata <= {16'h0000, v}; // whole 16-bit words only
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [31:0] ad, output logic [15:0] v);
    @(posedge clock);
    araddr <= ad;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clock);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    v = rdata[15:0];
    rready <= 1'h0;
  endtask

  // expected chip select, space and width
  function automatic logic [15:0] exp_dec(input logic [31:0] x);
    logic [2:0] s;
    logic [1:0] w;
    s = badc_pkg::SP_EXT;
    w = x[27] ? badc_pkg::W16 : badc_pkg::W8;
    if (x[26:24] == 3'h0) begin
      s = rom_en ? badc_pkg::SP_ROM : badc_pkg::SP_EXT;
      w = rom_en ? badc_pkg::W32 : (mode_pin ? badc_pkg::W16 : badc_pkg::W8);
    end
    if (x[26:24] == 3'h1 && mdl[0][15]) s = badc_pkg::SP_DRAM;
    if (x[26:24] == 3'h6) begin
      if (mdl[0][14]) s = badc_pkg::SP_MUXIO;
      if (!x[27]) w = x[14] ? badc_pkg::W16 : badc_pkg::W8;
    end
    if (x[26:24] == 3'h5 && x[badc_pkg::ONCHIP_BIT]) begin
      s = badc_pkg::SP_PERI;
      w = x[8] ? badc_pkg::W16 : badc_pkg::W8;
    end
    if (x[26:24] == 3'h7 && x[badc_pkg::ONCHIP_BIT]) begin
      s = badc_pkg::SP_RAM;
      w = badc_pkg::W32;
    end
    return {3'h0, 8'h01 << x[26:24], s, w};
  endfunction

  // expected pins {read, wrl, wrh, a0}; x[0] write, x[2:1] lanes
  function automatic logic [15:0] exp_pin(input logic [31:0] x);
    if (mdl[0][11]) return {12'h000, ~x[0], x[0], x[1], x[2]};
    return {12'h000, ~x[0], x[0] & x[1], x[0] & x[2], x[0]};
  endfunction

  task automatic acc(input logic [31:0] x);
    @(posedge clock);
    acc_addr <= x;
    acc_write <= x[0];
    acc_lanes <= x[2:1];
    acc_valid <= 1'h1;
    do @(posedge clock); while (dec_valid !== 1'h1);
    acc_valid <= 1'h0;
    chk_dec({3'h0, dec.chip_select, dec.space, dec.width},
      exp_dec(x));
    chk_dec({12'h000, dec.read_strobe, dec.pin_wrl, dec.pin_wrh,
      dec.pin_a0}, exp_pin(x));
  endtask

  // hang guard, the run needs well under a tenth of this
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h0b1d));
    repeat (5) @(posedge clock);
    rst_n <= 1'h1;
    repeat (4) @(posedge clock);
    chk_reg(16'(cfg), 16'h0000);
    for (i = 0; i < 10; i++) begin
      mdl[i] = rst_tbl[i];
      axr(img(i), d);
      chk_reg(d, mdl[i]);
    end
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 10; i++) begin
        d = 16'($urandom);
        axw(img(i), d);
        mdl[i] = (i == 0) ? (d & 16'hF800) : d;
      end
      axw({4'h0, 28'h5FFFFB4}, 16'hFFFF);
      axr({4'h0, 28'h5FFFFB4}, d);
      chk_reg(d, 16'h0000);
      for (i = 0; i < 10; i++) begin
        axr(img(i), d);
        chk_reg(d, mdl[i]);
      end
      chk_reg(16'(cfg),
        {11'h000, mdl[0][15:11]});
      chk_reg(dram_eff, mdl[0][15] ? mdl[4] : 16'h0000);
      mode_pin <= 1'($urandom);
      rom_en <= 1'($urandom);
      repeat (8) begin
        a = $urandom;
        acc(a);
      end
    end
    chk_reg(16'(n_acc != 0), 16'h0001);
    end_sim();
  end
endmodule // badc_top_tb
